// ---- core/sag_top.sv ----
// Segment address generator: segment choice, effective offset and physical address.
// Summary of operation
// - Four segment base registers: program, stack, data zero, data one.
// - Each bus cycle picks its segment register from the access type.
// - Instruction fetch uses program segment with the prefetch pointer.
// - Stack pointer accesses and frame-base offsets default to the stack segment.
// - Offsets without the frame base pointer default to data segment zero.
// - Fetch, stack pointer and group B destination segments ignore any override.
// - Other default offsets accept an override to another segment register.
// - Group A source reads use the source index, data zero default, overridable.
// - Group B destination writes use destination index with data segment one.
// - Group A: block transfer, block output, decimal string, bit field extract.
// - Group B: block transfer, block input, decimal string, bit field insert.
// - The effective offset is an unsigned 16-bit offset within the segment.
// - The mode byte selects how the effective offset is calculated.
// - Offset sums displacement, base and index in any combination.
// - Displacement is an 8-bit or 16-bit immediate.
// - Physical address is segment base shifted left four plus offset, unsigned.
// - Physical addresses span 20 bits, one megabyte.
// - Offset and address calculation complete in two clocks for every mode.
`timescale 1ns/1ps
`include "sag_defines.svh"
module sag_top (
   input  wire logic                   i_core_clk,
   input  wire logic                   i_srst,
   input  wire logic                   i_seg_wr_en,
   input  wire logic [1:0]             i_seg_wr_sel,
   input  wire logic [`SAG_OFF_W-1:0]  i_seg_wr_data,
   input  wire logic                   i_req_valid,
   output logic                        o_req_ready,
   input  wire logic [2:0]             i_access_kind,
   input  wire logic [2:0]             i_instr_class,
   input  wire logic                   i_override_valid,
   input  wire logic [1:0]             i_override_seg,
   input  wire logic [7:0]             i_mode_byte,
   input  wire logic [`SAG_OFF_W-1:0]  i_disp,
   input  wire logic [`SAG_OFF_W-1:0]  i_prefetch_offset_pointer,
   input  wire logic [`SAG_OFF_W-1:0]  i_stack_offset_pointer,
   input  wire logic [`SAG_OFF_W-1:0]  i_base_word,
   input  wire logic [`SAG_OFF_W-1:0]  i_frame_base_pointer,
   input  wire logic [`SAG_OFF_W-1:0]  i_source_index,
   input  wire logic [`SAG_OFF_W-1:0]  i_destination_index,
   output logic                        o_done,
   output logic                        o_refused,
   output logic [`SAG_PHYS_W-1:0]      o_phys_addr,
   output logic [`SAG_OFF_W-1:0]       o_effective_offset,
   output logic [1:0]                  o_seg_sel
);
   sag_pkg::sag_core_t core_reg;
   sag_pkg::sag_core_t core_next;
   sag_eff_if          eff_bus ();
   logic               accept;
   sag_pkg::sag_seg_t  pick_seg;
   logic [`SAG_OFF_W-1:0] pick_off;
   logic               pick_bad;

   function automatic logic in_group_a(input logic [2:0] cls);
      case (cls)
         sag_pkg::SAG_CL_BLOCK_MOVE, sag_pkg::SAG_CL_BLOCK_OUT,
         sag_pkg::SAG_CL_BCD_STRING, sag_pkg::SAG_CL_BIT_EXTRACT: in_group_a = 1'b1;
         default: in_group_a = 1'b0;
      endcase
   endfunction

   function automatic logic in_group_b(input logic [2:0] cls);
      case (cls)
         sag_pkg::SAG_CL_BLOCK_MOVE, sag_pkg::SAG_CL_BLOCK_IN,
         sag_pkg::SAG_CL_BCD_STRING, sag_pkg::SAG_CL_BIT_INSERT: in_group_b = 1'b1;
         default: in_group_b = 1'b0;
      endcase
   endfunction

   // An override naming the default register changes nothing, so it needs no filter.
   function automatic sag_pkg::sag_seg_t with_override(input sag_pkg::sag_seg_t dflt);
      with_override = i_override_valid ? sag_pkg::sag_seg_t'(i_override_seg) : dflt;
   endfunction

   assign eff_bus.mode_byte          = i_mode_byte;
   assign eff_bus.base_word          = i_base_word;
   assign eff_bus.frame_base_pointer = i_frame_base_pointer;
   assign eff_bus.source_index       = i_source_index;
   assign eff_bus.destination_index  = i_destination_index;
   assign eff_bus.disp_raw           = i_disp;

   sag_eff_calc u_eff_calc (
      .eo (eff_bus.calc)
   );

   always_comb begin
      pick_bad = 1'b0;
      pick_seg = sag_pkg::SAG_SEG_DATA0;
      pick_off = eff_bus.eff_sum;
      case (i_access_kind)
         sag_pkg::SAG_ACC_FETCH: begin
            pick_seg = sag_pkg::SAG_SEG_PROG;
            pick_off = i_prefetch_offset_pointer;
         end
         sag_pkg::SAG_ACC_STACK: begin
            pick_seg = sag_pkg::SAG_SEG_STACK;
            pick_off = i_stack_offset_pointer;
         end
         sag_pkg::SAG_ACC_OPERAND: begin
            pick_bad = eff_bus.reg_mode;
            pick_seg = with_override(eff_bus.uses_frame_base ?
                          sag_pkg::SAG_SEG_STACK : sag_pkg::SAG_SEG_DATA0);
         end
         sag_pkg::SAG_ACC_STR_SRC: begin
            pick_bad = !in_group_a(i_instr_class);
            pick_seg = with_override(sag_pkg::SAG_SEG_DATA0);
            pick_off = i_source_index;
         end
         sag_pkg::SAG_ACC_STR_DST: begin
            pick_bad = !in_group_b(i_instr_class);
            pick_seg = sag_pkg::SAG_SEG_DATA1;
            pick_off = i_destination_index;
         end
         default: pick_bad = 1'b1;
      endcase
   end

   assign o_req_ready = (core_reg.state == sag_pkg::SAG_ST_IDLE);
   assign accept      = i_req_valid && o_req_ready;

   always_comb begin
      core_next = core_reg;
      if (i_seg_wr_en) begin
         core_next.seg_base[i_seg_wr_sel] = i_seg_wr_data;
      end
      case (core_reg.state)
         sag_pkg::SAG_ST_IDLE: begin
            if (accept) begin
               core_next.state   = sag_pkg::SAG_ST_ADD;
               core_next.seg     = pick_seg;
               core_next.seg_val = core_reg.seg_base[pick_seg];
               core_next.eff     = pick_off;
               core_next.bad     = pick_bad;
            end
         end
         sag_pkg::SAG_ST_ADD: begin
            core_next.state = sag_pkg::SAG_ST_DONE;
            // Carry above bit 19 is dropped, wrapping within one megabyte.
            core_next.phys  = {core_reg.seg_val, {`SAG_SEG_SHIFT{1'b0}}}
                              + {{`SAG_SEG_SHIFT{1'b0}}, core_reg.eff};
         end
         sag_pkg::SAG_ST_DONE: core_next.state = sag_pkg::SAG_ST_IDLE;
         default:              core_next.state = sag_pkg::SAG_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         core_reg.state    <= sag_pkg::SAG_ST_IDLE;
         core_reg.seg_base <= {4{`SAG_SEG_RST}};
         core_reg.seg      <= sag_pkg::SAG_SEG_PROG;
         core_reg.seg_val  <= '0;
         core_reg.eff      <= '0;
         core_reg.phys     <= '0;
         core_reg.bad      <= 1'b0;
      end else begin
         core_reg <= core_next;
      end
   end

   assign o_done             = (core_reg.state == sag_pkg::SAG_ST_DONE) && !core_reg.bad;
   assign o_refused          = (core_reg.state == sag_pkg::SAG_ST_DONE) && core_reg.bad;
   assign o_phys_addr        = core_reg.phys;
   assign o_effective_offset = core_reg.eff;
   assign o_seg_sel          = core_reg.seg;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   property p_two_clocks;
      accept |=> !o_req_ready ##1 (!o_req_ready && (o_done || o_refused));
   endproperty
   a_two_clocks: assert property (p_two_clocks)
      else $error("answer not two clocks after accept");

   property p_phys_sum;
      o_done |-> o_phys_addr == 20'(({4'h0, core_reg.seg_val} << 4) + {4'h0, o_effective_offset});
   endproperty
   a_phys_sum: assert property (p_phys_sum)
      else $error("physical address differs from segment times 16 plus offset");

   property p_fetch;
      accept && i_access_kind == sag_pkg::SAG_ACC_FETCH |-> ##2
         o_seg_sel == `SAG_SEG_PROG && o_effective_offset == $past(i_prefetch_offset_pointer, 2);
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("fetch did not use program segment and prefetch pointer");

   property p_stack_fixed;
      accept && i_access_kind == sag_pkg::SAG_ACC_STACK |-> ##2 o_seg_sel == `SAG_SEG_STACK;
   endproperty
   a_stack_fixed: assert property (p_stack_fixed)
      else $error("stack pointer access left stack segment");

   property p_dst_fixed;
      accept && i_access_kind == sag_pkg::SAG_ACC_STR_DST && in_group_b(i_instr_class) |-> ##2
         o_done && o_seg_sel == `SAG_SEG_DATA1 && o_effective_offset == $past(i_destination_index, 2);
   endproperty
   a_dst_fixed: assert property (p_dst_fixed)
      else $error("destination write not in data segment one");

   property p_src_default;
      accept && i_access_kind == sag_pkg::SAG_ACC_STR_SRC && !i_override_valid |-> ##2
         o_seg_sel == `SAG_SEG_DATA0;
   endproperty
   a_src_default: assert property (p_src_default)
      else $error("source read default segment wrong");

   property p_override;
      accept && i_access_kind == sag_pkg::SAG_ACC_OPERAND && i_override_valid |-> ##2
         o_seg_sel == $past(i_override_seg, 2);
   endproperty
   a_override: assert property (p_override)
      else $error("override not applied");

   property p_operand_default;
      accept && i_access_kind == sag_pkg::SAG_ACC_OPERAND && !i_override_valid |-> ##2
         o_seg_sel == ($past(eff_bus.uses_frame_base, 2) ? `SAG_SEG_STACK : `SAG_SEG_DATA0);
   endproperty
   a_operand_default: assert property (p_operand_default)
      else $error("operand default segment wrong");

   property p_bad_group;
      accept && i_access_kind == sag_pkg::SAG_ACC_STR_SRC && !in_group_a(i_instr_class)
         |-> ##2 o_refused && !o_done;
   endproperty
   a_bad_group: assert property (p_bad_group)
      else $error("source read outside group A not refused");

   c_fetch:    cover property (accept && i_access_kind == sag_pkg::SAG_ACC_FETCH ##2 o_done);
   c_override: cover property (accept && i_override_valid ##2 o_done);
   c_wrap:     cover property (o_done && o_phys_addr < {4'h0, o_effective_offset});
   c_refused:  cover property (o_refused);
endmodule

// ---- core/sag_defines.svh ----
// Constants for the segment address generator.
`ifndef SAG_DEFINES_SVH
`define SAG_DEFINES_SVH
`define SAG_OFF_W       16
`define SAG_PHYS_W      20
`define SAG_SEG_SHIFT   4
`define SAG_SEG_RST     16'h0000
`define SAG_SEG_PROG    2'h0
`define SAG_SEG_STACK   2'h1
`define SAG_SEG_DATA0   2'h2
`define SAG_SEG_DATA1   2'h3
`define SAG_EFF_CLOCKS  2
`define SAG_MOD_MSB     7
`define SAG_MOD_LSB     6
`define SAG_RM_MSB      2
`define SAG_RM_LSB      0
`define SAG_MOD_NODISP  2'h0
`define SAG_MOD_DISP8   2'h1
`define SAG_MOD_DISP16  2'h2
`define SAG_MOD_REG     2'h3
`define SAG_RM_DIRECT   3'h6
`endif

// ---- core/sag_pkg.sv ----
// Types shared by the segment address generator modules.
`include "sag_defines.svh"
package sag_pkg;
   typedef enum logic [1:0] {
      SAG_SEG_PROG  = `SAG_SEG_PROG,
      SAG_SEG_STACK = `SAG_SEG_STACK,
      SAG_SEG_DATA0 = `SAG_SEG_DATA0,
      SAG_SEG_DATA1 = `SAG_SEG_DATA1
   } sag_seg_t;

   typedef enum logic [2:0] {
      SAG_ACC_FETCH   = 3'h0,
      SAG_ACC_STACK   = 3'h1,
      SAG_ACC_OPERAND = 3'h2,
      SAG_ACC_STR_SRC = 3'h3,
      SAG_ACC_STR_DST = 3'h4
   } sag_access_t;

   typedef enum logic [2:0] {
      SAG_CL_OTHER       = 3'h0,
      SAG_CL_BLOCK_MOVE  = 3'h1,
      SAG_CL_BLOCK_OUT   = 3'h2,
      SAG_CL_BLOCK_IN    = 3'h3,
      SAG_CL_BCD_STRING  = 3'h4,
      SAG_CL_BIT_EXTRACT = 3'h5,
      SAG_CL_BIT_INSERT  = 3'h6
   } sag_class_t;

   typedef enum logic [2:0] {
      SAG_ST_IDLE = 3'h1,
      SAG_ST_ADD  = 3'h2,
      SAG_ST_DONE = 3'h4
   } sag_state_t;

   typedef struct packed {
      sag_state_t                    state;
      logic [3:0][`SAG_OFF_W-1:0]    seg_base;
      sag_seg_t                      seg;
      logic [`SAG_OFF_W-1:0]         seg_val;
      logic [`SAG_OFF_W-1:0]         eff;
      logic [`SAG_PHYS_W-1:0]        phys;
      logic                          bad;
   } sag_core_t;
endpackage

// ---- core/sag_ea_if.sv ----
// Interface between the address generator and its effective offset adder.
`timescale 1ns/1ps
`include "sag_defines.svh"
interface sag_eff_if;
   logic [7:0]            mode_byte;
   logic [`SAG_OFF_W-1:0] base_word;
   logic [`SAG_OFF_W-1:0] frame_base_pointer;
   logic [`SAG_OFF_W-1:0] source_index;
   logic [`SAG_OFF_W-1:0] destination_index;
   logic [`SAG_OFF_W-1:0] disp_raw;
   logic [`SAG_OFF_W-1:0] eff_sum;
   logic                  uses_frame_base;
   logic                  reg_mode;
   modport calc (input mode_byte, base_word, frame_base_pointer, source_index,
                 destination_index, disp_raw, output eff_sum, uses_frame_base, reg_mode);
   modport user (output mode_byte, base_word, frame_base_pointer, source_index,
                 destination_index, disp_raw, input eff_sum, uses_frame_base, reg_mode);
endinterface

// ---- core/sag_ea_calc.sv ----
// Effective offset adder: decodes the mode byte and sums displacement, base and index.
`timescale 1ns/1ps
`include "sag_defines.svh"
module sag_eff_calc (
   sag_eff_if.calc eo
);
   logic [1:0]            mode;
   logic [2:0]            rm;
   logic [`SAG_OFF_W-1:0] base_term;
   logic [`SAG_OFF_W-1:0] index_term;
   logic [`SAG_OFF_W-1:0] disp_term;

   assign mode = eo.mode_byte[`SAG_MOD_MSB:`SAG_MOD_LSB];
   assign rm   = eo.mode_byte[`SAG_RM_MSB:`SAG_RM_LSB];

   always_comb begin
      base_term          = '0;
      index_term         = '0;
      eo.uses_frame_base = 1'b0;
      case (rm)
         3'h0: begin
            base_term  = eo.base_word;
            index_term = eo.source_index;
         end
         3'h1: begin
            base_term  = eo.base_word;
            index_term = eo.destination_index;
         end
         3'h2: begin
            base_term          = eo.frame_base_pointer;
            index_term         = eo.source_index;
            eo.uses_frame_base = 1'b1;
         end
         3'h3: begin
            base_term          = eo.frame_base_pointer;
            index_term         = eo.destination_index;
            eo.uses_frame_base = 1'b1;
         end
         3'h4: index_term = eo.source_index;
         3'h5: index_term = eo.destination_index;
         3'h6: begin
            // With no displacement field this encoding is a bare 16-bit address.
            if (mode != `SAG_MOD_NODISP) begin
               base_term          = eo.frame_base_pointer;
               eo.uses_frame_base = 1'b1;
            end
         end
         default: base_term = eo.base_word;
      endcase
   end

   always_comb begin
      eo.reg_mode = 1'b0;
      case (mode)
         `SAG_MOD_NODISP: disp_term = (rm == `SAG_RM_DIRECT) ? eo.disp_raw : '0;
         `SAG_MOD_DISP8:  disp_term = {{8{eo.disp_raw[7]}}, eo.disp_raw[7:0]};
         `SAG_MOD_DISP16: disp_term = eo.disp_raw;
         default: begin
            disp_term   = '0;
            eo.reg_mode = 1'b1;
         end
      endcase
   end

   // The sum keeps 16 bits, so offsets wrap inside the segment.
   assign eo.eff_sum = base_term + index_term + disp_term;
endmodule

// ---- dv/sag_bcu_model.sv ----
// Bus control unit stand-in that records each address handed over by the generator.
`timescale 1ns/1ps
`include "sag_defines.svh"
module sag_bcu_model (
   input  wire logic                   i_core_clk,
   input  wire logic                   i_srst,
   input  wire logic                   i_done,
   input  wire logic [`SAG_PHYS_W-1:0] i_phys_addr,
   input  wire logic [`SAG_OFF_W-1:0]  i_effective_offset,
   input  wire logic [1:0]             i_seg_sel,
   output logic [`SAG_PHYS_W-1:0]      o_last_phys,
   output logic [`SAG_OFF_W-1:0]       o_last_offset,
   output logic [1:0]                  o_last_seg
);
   // The address is taken only on the done pulse, so a stale or refused answer never lands.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_last_phys   <= '0;
         o_last_offset <= '0;
         o_last_seg    <= '0;
      end else if (i_done) begin
         o_last_phys   <= i_phys_addr;
         o_last_offset <= i_effective_offset;
         o_last_seg    <= i_seg_sel;
      end
   end
endmodule

// ---- dv/segment_address_generator_tb.sv ----
// Self-checking bench for the segment address generator against a behavioural model.
`timescale 1ns/1ps
`include "sag_defines.svh"
module segment_address_generator_tb;
   logic                   clk = 1'b0;
   logic                   srst = 1'b1;
   logic                   wen = 1'b0;
   logic                   vld = 1'b0;
   logic                   ovv = 1'b0;
   logic [1:0]             wsel = 2'h0;
   logic [1:0]             ovs = 2'h0;
   logic [2:0]             kind = 3'h0;
   logic [2:0]             cls = 3'h0;
   logic [7:0]             mb = 8'h00;
   logic [`SAG_OFF_W-1:0]  wdat = 16'h0000, disp = 16'h0000, pfo = 16'h0000, stk = 16'h0000;
   logic [`SAG_OFF_W-1:0]  bw = 16'h0000, fbp = 16'h0000, si = 16'h0000, di = 16'h0000;
   logic                   rdy, done, refd;
   logic [`SAG_PHYS_W-1:0] phys, bphys;
   logic [`SAG_OFF_W-1:0]  eoff, boff;
   logic [1:0]             ssel, bseg;
   int                     seg_m [4] = '{0, 0, 0, 0};
   int                     n_mismatch = 0;
   int                     checks = 0;

   initial begin
      forever #5 clk = ~clk;
   end

   sag_top sag_top_i (.i_core_clk(clk), .i_srst(srst), .i_seg_wr_en(wen), .i_seg_wr_sel(wsel),
      .i_seg_wr_data(wdat), .i_req_valid(vld), .o_req_ready(rdy), .i_access_kind(kind),
      .i_instr_class(cls), .i_override_valid(ovv), .i_override_seg(ovs), .i_mode_byte(mb),
      .i_disp(disp), .i_prefetch_offset_pointer(pfo), .i_stack_offset_pointer(stk),
      .i_base_word(bw), .i_frame_base_pointer(fbp), .i_source_index(si),
      .i_destination_index(di), .o_done(done), .o_refused(refd), .o_phys_addr(phys),
      .o_effective_offset(eoff), .o_seg_sel(ssel));

   sag_bcu_model sag_bcu_model_i (.i_core_clk(clk), .i_srst(srst), .i_done(done),
      .i_phys_addr(phys), .i_effective_offset(eoff), .i_seg_sel(ssel),
      .o_last_phys(bphys), .o_last_offset(boff), .o_last_seg(bseg));

   task automatic end_sim();
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic rand_ops();
      {disp, pfo, stk, bw} = {$urandom, $urandom};
      {fbp, si, di, wdat} = {$urandom, $urandom};
   endtask

   // An idle cycle follows each write, so back-to-back writes never lower and raise
   // the strobe in one time step.
   task automatic wr_seg(input logic [1:0] s, input logic [15:0] d);
      {wen, wsel, wdat} = {1'b1, s, d};
      @(negedge clk);
      wen = 1'b0;
      seg_m[s] = int'(d);
      @(negedge clk);
   endtask

   // The model is evaluated before the request goes out, so a segment write in the
   // taking cycle lands in the model only after the expectation is fixed.
   task automatic req(input logic [2:0] k, input logic [2:0] c, input logic v,
                      input logic [1:0] s, input logic [7:0] m, input logic w);
      int   rm, md, sg, off, ph;
      logic bad, bpb;
      rm = int'(m[2:0]);
      md = int'(m[7:6]);
      bpb = rm inside {2, 3} || (rm == 6 && md != 0);
      bad = k > 3'h4 || (k == 3'h2 && md == 3) || (k == 3'h3 && !(c inside {1, 2, 4, 5}))
            || (k == 3'h4 && !(c inside {1, 3, 4, 6}));
      off = (rm inside {0, 1, 7}) ? int'(bw) : bpb ? int'(fbp) : 0;
      off += (rm inside {0, 2, 4}) ? int'(si) : (rm inside {1, 3, 5}) ? int'(di) : 0;
      off += (md == 1) ? int'($signed(disp[7:0]))
             : (md == 2 || (md == 0 && rm == 6)) ? int'(disp) : 0;
      if (k != 3'h2) off = (k == 3'h0) ? int'(pfo) : (k == 3'h1) ? int'(stk)
                           : (k == 3'h3) ? int'(si) : int'(di);
      off = off & 'hffff;
      sg = (k == 3'h0) ? 0 : (k == 3'h1 || (k == 3'h2 && bpb)) ? 1 : (k == 3'h4) ? 3 : 2;
      if (v && (k == 3'h2 || k == 3'h3)) sg = int'(s);
      ph = ((seg_m[sg] << 4) + off) & 'hfffff;
      {kind, cls, ovv, ovs, mb} = {k, c, v, s, m};
      while (rdy !== 1'b1) @(negedge clk);
      vld = 1'b1;
      wen = w;
      wsel = 2'($urandom);
      @(negedge clk);
      vld = 1'b0;
      wen = 1'b0;
      if (w) seg_m[wsel] = int'(wdat);
      chk(rdy === 1'b0 && done === 1'b0, "busy cycle");
      @(negedge clk);
      chk(done === !bad && refd === bad, "answer flags");
      if (!bad) chk(eoff === off[15:0], "effective offset");
      if (!bad) chk(ssel === sg[1:0], "segment choice");
      if (!bad) chk(phys === ph[19:0], "physical address");
      @(negedge clk);
      chk(rdy === 1'b1 && done === 1'b0 && refd === 1'b0, "idle again");
      if (!bad) chk(bphys === ph[19:0] && boff === off[15:0] && bseg === sg[1:0], "bus copy");
   endtask

   initial begin
      void'($urandom(49873));
      repeat (10) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      chk(rdy === 1'b1 && done === 1'b0 && refd === 1'b0 && phys === 20'h00000
          && eoff === 16'h0000 && ssel === 2'h0, "reset");
      rand_ops();
      req(3'h0, 3'h0, 1'b1, 2'h2, 8'h00, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr_seg(2'(i), 16'($urandom));
      end
      for (int m = 0; m < 32; m++) begin
         rand_ops();
         req(3'h2, 3'h0, 1'b0, 2'h0, {m[4:3], 3'h0, m[2:0]}, 1'b0);
      end
      for (int c = 0; c < 7; c++) begin
         req(3'h3, 3'(c), 1'b1, 2'(c), 8'h00, 1'b0);
         req(3'h4, 3'(c), 1'b1, 2'(c), 8'h00, 1'b0);
      end
      for (int o = 0; o < 4; o++) begin
         req(3'h1, 3'h0, 1'b1, 2'(o), 8'h46, 1'b0);
         req(3'h2, 3'h0, 1'b1, 2'(o), 8'h46, 1'b0);
         req(3'h2, 3'h0, 1'b1, 2'(o), 8'h87, 1'b0);
      end
      wr_seg(2'h2, 16'hffff);
      {bw, si, disp} = {16'hffff, 16'hfff0, 16'h7fff};
      req(3'h2, 3'h0, 1'b0, 2'h0, 8'h80, 1'b0);
      for (int n = 0; n < 200; n++) begin
         rand_ops();
         req(3'($urandom_range(0, 7)), 3'($urandom_range(0, 6)), 1'($urandom),
             2'($urandom), 8'($urandom), 1'($urandom));
      end
      // A reset in mid-run must clear the segment registers written above.
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      seg_m = '{0, 0, 0, 0};
      @(negedge clk);
      chk(rdy === 1'b1 && done === 1'b0 && refd === 1'b0 && phys === 20'h00000
          && eoff === 16'h0000 && ssel === 2'h0, "second reset");
      rand_ops();
      req(3'h1, 3'h0, 1'b0, 2'h0, 8'h00, 1'b0);
      end_sim();
   end

   // Roughly four times the expected run, so a stuck handshake ends the run.
   initial begin
      repeat (3500) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
endmodule
